// File: rtl/wdtwk_cfg.svh
`ifndef WDTWK_CFG_SVH
`define WDTWK_CFG_SVH

// ==========================================================
// sfr byte addresses
`define WDTWK_SFR_DATA_LOW      8'hb3
`define WDTWK_SFR_DATA_HIGH     8'hb4
`define WDTWK_SFR_CONTROL       8'hb5
`define WDTWK_SFR_TICK_DIV      8'hb6

// ==========================================================
// bridge control field positions
`define WDTWK_CTL_BUSY_BIT      5
`define WDTWK_CTL_WR_BIT        4
`define WDTWK_CTL_ADDR_MSB      3

// ==========================================================
// indirect addresses
`define WDTWK_IX_WDT_START      4'h0
`define WDTWK_IX_CMP_HIGH       4'h3
`define WDTWK_IX_CMP_LOW        4'h4
`define WDTWK_IX_WAKE_CTRL      4'h5
`define WDTWK_IX_CAP_LOW        4'h6
`define WDTWK_IX_CAP_HIGH       4'h7

// ==========================================================
// wake control word fields
`define WDTWK_WAKE_CONTROL_WORD_WDT_RST_BIT  5
`define WDTWK_WAKE_CONTROL_WORD_CAPTURE_BIT  4
`define WDTWK_WAKE_CONTROL_WORD_MODE_MSB     1
`define WDTWK_MODE_PERIODIC     2'h3

// ==========================================================
// reset values and widths
`define WDTWK_TICK_DIV_RESET    8'h03
`define WDTWK_DATA_RESET        8'h00
`define WDTWK_WDT_ZERO          16'h0000
`define WDTWK_WDT_ALL_ONES      16'hffff
`define WDTWK_TIMER_WIDTH       24
`define WDTWK_FINE_WIDTH        8
`define WDTWK_LF_NOMINAL_HZ     32000

`endif

// File: rtl/wdtwk_pkg.sv
`default_nettype none

package wdtwk_pkg;

    // ==========================================================
    // sfr access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdtwk_sfr_req_s;

    // ==========================================================
    // wake timer control carried into the timer
    typedef struct packed {
        logic        run;
        logic        periodic;
        logic [23:0] compare;
    } wdtwk_wake_cfg_s;

endpackage : wdtwk_pkg

`default_nettype wire

// File: rtl/wdtwk_sync.sv
`default_nettype none

module wdtwk_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // ==========================================================
    // two flops, first one read only by the second
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : wdtwk_sync

`default_nettype wire

// File: rtl/wdtwk_wake_timer.sv
`include "wdtwk_cfg.svh"
`default_nettype none

module wdtwk_wake_timer #(
    parameter int TW = `WDTWK_TIMER_WIDTH,
    parameter int FW = `WDTWK_FINE_WIDTH
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_lf_edge,
    input  wire wdtwk_pkg::wdtwk_wake_cfg_s i_cfg,
    input  wire logic                       i_capture,
    output logic                            o_match,
    output logic [TW-1:0]                   o_cap_timer,
    output logic [FW-1:0]                   o_cap_fine
);
    import wdtwk_pkg::*;

    logic [TW-1:0] timer;
    logic [FW-1:0] fine;
    logic          hit;

    assign hit = (timer == i_cfg.compare[TW-1:0]);

    // ==========================================================
    // counter; i_reset, a clear run bit or a periodic match clears it, watchdog reset leaves it
    // no lf edge means no change, so a stopped lf clock holds the count
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            timer <= '0;
        end else if (!i_cfg.run) begin
            timer <= '0;
        end else if (i_lf_edge) begin
            if (hit && i_cfg.periodic) begin
                timer <= '0;
            end else begin
                timer <= timer + 1'b1;
            end
        end
    end

    // compare read live, so a new value applies at once
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_match <= 1'b0;
        end else begin
            o_match <= i_cfg.run && i_lf_edge && hit;
        end
    end

    // ==========================================================
    // fine count of core cycles since the last lf rising edge
    // saturates: the lf period is longer than the field can hold
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fine <= '0;
        end else if (i_lf_edge) begin
            fine <= '0;
        end else if (fine != {FW{1'b1}}) begin
            fine <= fine + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_cap_timer <= '0;
            o_cap_fine  <= '0;
        end else if (i_capture) begin
            o_cap_timer <= timer;
            o_cap_fine  <= fine;
        end
    end

endmodule : wdtwk_wake_timer

`default_nettype wire

// File: rtl/wdtwk_top.sv
`include "wdtwk_cfg.svh"
`default_nettype none

module wdtwk_top (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    input  wire wdtwk_pkg::wdtwk_sfr_req_s i_sfr,
    input  wire logic                      i_low_freq_clock,
    input  wire logic                      i_pin_wake,
    input  wire logic                      i_sleep_entry,
    input  wire logic                      i_capture,
    output logic [7:0]                     o_sfr_rdata,
    output logic                           o_wdt_reset,
    output logic                           o_wdt_active,
    output logic                           o_wake_irq,
    output logic                           o_wake_by_pin
);
    import wdtwk_pkg::*;

    // ==========================================================
    // declarations
    logic        lf_sync;
    logic        pin_sync;
    logic        lf_prev;
    logic        pin_prev;
    logic        lf_edge;
    logic        pin_event;
    logic        sys_reset;
    logic        sfr_wr_ok;

    logic [7:0]  data_high;
    logic [7:0]  data_low;
    logic [15:0] data_word;
    logic        busy;
    logic        xfer_wr;
    logic [3:0]  xfer_addr;
    logic        xfer_done;
    logic        load_wdt;
    logic [15:0] next_read;

    logic [7:0]  tick_divider;
    logic [7:0]  tick_cnt;
    logic [15:0] wdt_start;
    logic [15:0] wdt_count;
    logic        wdt_fire;
    logic        wdt_stop;
    logic        wdt_expire;

    logic [7:0]  cmp_high;
    logic [15:0] cmp_low;
    logic [15:0] wake_ctrl;
    logic        capture;
    logic        match;
    logic [23:0] cap_timer;
    logic [7:0]  cap_fine;
    wdtwk_wake_cfg_s wake_cfg;

    // ==========================================================
    // pin and lf clock synchronisers, edge detection
    wdtwk_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_low_freq_clock, i_pin_wake}),
        .o_sync  ({lf_sync, pin_sync})
    );

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lf_prev  <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            lf_prev  <= lf_sync;
            pin_prev <= pin_sync;
        end
    end

    // everything on the lf side only moves at an lf rising edge
    assign lf_edge   = lf_sync & ~lf_prev;
    assign pin_event = pin_sync & ~pin_prev;

    // watchdog expiry resets the bridge, read port, tick divider and watchdog; not the wake timer, its words, synchronisers or wake outputs
    assign sys_reset = i_reset | wdt_fire;

    // ==========================================================
    // bridge data and control registers
    assign data_word = {data_high, data_low};
    assign sfr_wr_ok = i_sfr.wr && !busy;
    assign xfer_done = busy && lf_edge;
    assign load_wdt  = xfer_done && xfer_wr && (xfer_addr == `WDTWK_IX_WDT_START);

    always_comb begin
        case (xfer_addr)
            `WDTWK_IX_WDT_START: next_read = wdt_start;
            `WDTWK_IX_CMP_HIGH:  next_read = {8'h00, cmp_high};
            `WDTWK_IX_CMP_LOW:   next_read = cmp_low;
            `WDTWK_IX_WAKE_CTRL: next_read = wake_ctrl;
            `WDTWK_IX_CAP_LOW:   next_read = cap_timer[15:0];
            `WDTWK_IX_CAP_HIGH:  next_read = {cap_fine, cap_timer[23:16]};
            default:             next_read = 16'h0000;
        endcase
    end

    // core write of a data byte wins over a read result landing
    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            data_high <= `WDTWK_DATA_RESET;
            data_low  <= `WDTWK_DATA_RESET;
        end else begin
            if (xfer_done && !xfer_wr) begin
                data_high <= next_read[15:8];
                data_low  <= next_read[7:0];
            end
            if (i_sfr.wr && i_sfr.addr == `WDTWK_SFR_DATA_HIGH) begin
                data_high <= i_sfr.wdata;
            end
            if (i_sfr.wr && i_sfr.addr == `WDTWK_SFR_DATA_LOW) begin
                data_low <= i_sfr.wdata;
            end
        end
    end

    // control writes while busy are dropped, not queued
    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            busy      <= 1'b0;
            xfer_wr   <= 1'b0;
            xfer_addr <= 4'h0;
        end else if (sfr_wr_ok && i_sfr.addr == `WDTWK_SFR_CONTROL) begin
            busy      <= 1'b1;
            xfer_wr   <= i_sfr.wdata[`WDTWK_CTL_WR_BIT];
            xfer_addr <= i_sfr.wdata[`WDTWK_CTL_ADDR_MSB:0];
        end else if (xfer_done) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            tick_divider <= `WDTWK_TICK_DIV_RESET;
        end else if (i_sfr.wr && i_sfr.addr == `WDTWK_SFR_TICK_DIV) begin
            tick_divider <= i_sfr.wdata;
        end
    end

    // ==========================================================
    // sfr read port
    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr.rd) begin
            case (i_sfr.addr)
                `WDTWK_SFR_DATA_LOW:  o_sfr_rdata <= data_low;
                `WDTWK_SFR_DATA_HIGH: o_sfr_rdata <= data_high;
                `WDTWK_SFR_CONTROL:   o_sfr_rdata <= {2'b00, busy,
                                                      xfer_wr, xfer_addr};
                `WDTWK_SFR_TICK_DIV:  o_sfr_rdata <= tick_divider;
                default:              o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // watchdog
    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            wdt_start <= `WDTWK_WDT_ZERO;
        end else if (load_wdt) begin
            wdt_start <= data_word;
        end
    end

    // a reload or sleep stop in the expiry cycle wins, so no stray reset
    assign wdt_stop   = i_sleep_entry && wake_ctrl[`WDTWK_WAKE_CONTROL_WORD_WDT_RST_BIT];
    assign wdt_expire = o_wdt_active && lf_edge && (tick_cnt == tick_divider)
                        && (wdt_count == 16'h0001) && !load_wdt && !wdt_stop;

    // timeout is start count (0 loads 65535) times (divider + 1) lf periods
    always_ff @(posedge i_clk) begin
        if (sys_reset) begin
            o_wdt_active <= 1'b0;
            wdt_count    <= `WDTWK_WDT_ZERO;
            tick_cnt     <= 8'h00;
        end else if (load_wdt) begin
            o_wdt_active <= 1'b1;
            tick_cnt     <= 8'h00;
            if (data_word == `WDTWK_WDT_ZERO) begin
                wdt_count <= `WDTWK_WDT_ALL_ONES;
            end else begin
                wdt_count <= data_word;
            end
        end else if (wdt_stop) begin
            o_wdt_active <= 1'b0;
            wdt_count    <= `WDTWK_WDT_ZERO;
            tick_cnt     <= 8'h00;
        end else if (o_wdt_active && lf_edge) begin
            if (tick_cnt == tick_divider) begin
                tick_cnt  <= 8'h00;
                wdt_count <= wdt_count - 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // one-cycle pulse; it is its own reset so it clears next cycle
    always_ff @(posedge i_clk) begin
        if (i_reset || wdt_fire) begin
            wdt_fire <= 1'b0;
        end else begin
            wdt_fire <= wdt_expire;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wdt_reset <= 1'b0;
        end else begin
            o_wdt_reset <= wdt_expire && !wdt_fire;
        end
    end

    // ==========================================================
    // wake timer words: only i_reset, never the watchdog, clears them
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmp_high  <= 8'h00;
            cmp_low   <= 16'h0000;
            wake_ctrl <= 16'h0000;
        end else if (xfer_done && xfer_wr) begin
            case (xfer_addr)
                `WDTWK_IX_CMP_HIGH:  cmp_high  <= data_low;
                `WDTWK_IX_CMP_LOW:   cmp_low   <= data_word;
                `WDTWK_IX_WAKE_CTRL: wake_ctrl <= data_word;
                default:             cmp_high  <= cmp_high;
            endcase
        end
    end

    assign wake_cfg.run      = wake_ctrl[`WDTWK_WAKE_CONTROL_WORD_MODE_MSB];
    assign wake_cfg.periodic = (wake_ctrl[`WDTWK_WAKE_CONTROL_WORD_MODE_MSB:0]
                                == `WDTWK_MODE_PERIODIC);
    assign wake_cfg.compare  = {cmp_high, cmp_low};
    assign capture = i_capture || (xfer_done && xfer_wr && xfer_addr == `WDTWK_IX_WAKE_CTRL
                     && data_low[`WDTWK_WAKE_CONTROL_WORD_CAPTURE_BIT]);

    // matches only at lf edges: first wake may be off by one period
    wdtwk_wake_timer #(
        .TW (`WDTWK_TIMER_WIDTH),
        .FW (`WDTWK_FINE_WIDTH)
    ) u_wake (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_lf_edge   (lf_edge),
        .i_cfg       (wake_cfg),
        .i_capture   (capture),
        .o_match     (match),
        .o_cap_timer (cap_timer),
        .o_cap_fine  (cap_fine)
    );

    // ==========================================================
    // shared wake line and its source bit
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wake_irq    <= 1'b0;
            o_wake_by_pin <= 1'b0;
        end else begin
            o_wake_irq <= match || pin_event;
            if (pin_event) begin
                o_wake_by_pin <= 1'b1;
            end else if (match) begin
                o_wake_by_pin <= 1'b0;
            end
        end
    end

endmodule : wdtwk_top

`default_nettype wire

// File: verification/wdtwk_top_properties.sv
`default_nettype none

module wdtwk_top_properties (
    input wire logic                      i_clk,
    input wire logic                      i_reset,
    input wire wdtwk_pkg::wdtwk_sfr_req_s i_sfr,
    input wire logic [7:0]                o_sfr_rdata,
    input wire logic                      o_wdt_reset,
    input wire logic                      o_wdt_active,
    input wire logic                      o_wake_irq,
    input wire logic                      o_wake_by_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import wdtwk_pkg::*;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // ==========================================================
    // control register accesses
    sequence s_ctl_write;
        i_sfr.wr && (i_sfr.addr == 8'hb5);
    endsequence
    sequence s_ctl_read;
        i_sfr.rd && (i_sfr.addr == 8'hb5);
    endsequence

    // ==========================================================
    // checks
    a_reset_quiet: assert property (
        $fell(i_reset) |-> !o_wdt_active && !o_wake_irq && (o_sfr_rdata == 8'h00))
        else $error("outputs not idle after reset");
    a_wdt_pulse_one: assert property (o_wdt_reset |=> !o_wdt_reset)
        else $error("watchdog reset longer than one cycle");
    a_wdt_self_stop: assert property (o_wdt_reset |-> ##[1:2] !o_wdt_active)
        else $error("watchdog still active after its reset");
    a_idle_no_fire: assert property (!o_wdt_active |-> !o_wdt_reset)
        else $error("idle watchdog fired");
    a_rdata_hold: assert property (
        !i_sfr.rd && !o_wdt_reset |=> $stable(o_sfr_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        i_sfr.rd && !(i_sfr.addr inside {[8'hb3:8'hb6]}) |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_reserved: assert property (s_ctl_read |=> o_sfr_rdata[7:6] == 2'b00)
        else $error("control reserved bits set");
    a_busy_after: assert property (s_ctl_write ##2 s_ctl_read |=> o_sfr_rdata[5])
        else $error("busy not shown after control write");
    a_pin_source: assert property ($rose(o_wake_by_pin) |-> o_wake_irq)
        else $error("pin source flag without wake pulse");
endmodule : wdtwk_top_properties

bind wdtwk_top wdtwk_top_properties i_props (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_sfr         (i_sfr),
    .o_sfr_rdata   (o_sfr_rdata),
    .o_wdt_reset   (o_wdt_reset),
    .o_wdt_active  (o_wdt_active),
    .o_wake_irq    (o_wake_irq),
    .o_wake_by_pin (o_wake_by_pin)
);

`default_nettype wire

// File: verification/wdtwk_core_model.sv
`default_nettype none

module wdtwk_core_model (
    input  wire logic                     i_clk,
    input  wire logic [7:0]               i_rdata,
    output var wdtwk_pkg::wdtwk_sfr_req_s o_sfr
);
    timeunit 1ns;
    timeprecision 1ns;
    import wdtwk_pkg::*;

    initial o_sfr = '0;

    // ==========================================================
    // byte accesses; idle bus shows inverted values, not the last ones
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge i_clk);
        o_sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        o_sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(posedge i_clk);
        o_sfr <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        #1;
        v = i_rdata;
    endtask : sfr_read

    // ==========================================================
    // indirect access; late is set when busy never clears
    task automatic ix_access(input logic wr, input logic [3:0] idx, input logic [15:0] val,
                             output logic [15:0] rval, output logic late);
        logic [7:0] c;
        logic [7:0] h;
        logic [7:0] l;
        int         n;
        late = 1'b1;
        if (wr) begin
            sfr_write(8'hb4, val[15:8]);
            sfr_write(8'hb3, val[7:0]);
        end
        sfr_write(8'hb5, {3'b000, wr, idx});
        for (n = 0; n < 100; n++) begin
            sfr_read(8'hb5, c);
            if (c[5] === 1'b0) begin
                late = 1'b0;
                break;
            end
        end
        sfr_read(8'hb4, h);
        sfr_read(8'hb3, l);
        rval = {h, l};
    endtask : ix_access
endmodule : wdtwk_core_model

`default_nettype wire

// File: verification/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wdtwk_pkg::*;

    // ==========================================================
    // signals
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    logic           lf = 1'b0;
    logic           pin = 1'b0;
    logic           sleep = 1'b0;
    logic           cap = 1'b0;
    wdtwk_sfr_req_s sfr;
    logic [7:0]     rdata;
    logic           wdt_reset;
    logic           wdt_active;
    logic           wake_irq;
    logic           by_pin;
    logic [7:0]     rd8;
    logic [15:0]    rv;
    logic [31:0]    seed = 32'h3303c5dd;
    int             lf_count = 0;
    int             err_total = 0;
    int             check_count = 0;
    int             k, n, d, s, j;

    always #25 clk = ~clk;
    // lf much faster than nominal to keep the run short
    always #1000 lf = ~lf;
    always @(posedge lf) begin
        lf_count++;
    end

    wdtwk_top i_dut (
        .i_clk            (clk),
        .i_reset          (reset),
        .i_sfr            (sfr),
        .i_low_freq_clock (lf),
        .i_pin_wake       (pin),
        .i_sleep_entry    (sleep),
        .i_capture        (cap),
        .o_sfr_rdata      (rdata),
        .o_wdt_reset      (wdt_reset),
        .o_wdt_active     (wdt_active),
        .o_wake_irq       (wake_irq),
        .o_wake_by_pin    (by_pin)
    );

    wdtwk_core_model i_core (
        .i_clk   (clk),
        .i_rdata (rdata),
        .o_sfr   (sfr)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        check_count++;
        if (seen !== expected) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic ix(input logic wr, input logic [3:0] idx, input logic [15:0] val);
        logic late;
        i_core.ix_access(wr, idx, val, rv, late);
        if (late) begin
            err_total++;
            close_out();
        end
    endtask : ix

    task automatic wait_pulse(input logic wake);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(posedge clk);
            #1;
            if ((wake ? wake_irq : wdt_reset) === 1'b1) begin
                return;
            end
        end
        $display("timeout at %0t", $time);
        err_total++;
        close_out();
    endtask : wait_pulse

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        i_core.sfr_read(8'hb6, rd8);
        check(rd8, 8'h03);
        i_core.sfr_read(8'hb4, rd8);
        check(rd8, 8'h00);
        i_core.sfr_read(8'hb0, rd8);
        check(rd8, 8'h00);
        check(wdt_active, 1'b0);
        $display("reset state test done");
        for (j = 0; j < 2; j++) begin
            seed = lfsr_next(seed);
            k = 2 + seed[1:0];
            ix(1'b1, 4'h5, 16'h0000);
            ix(1'b1, 4'h3, 16'h0000);
            ix(1'b1, 4'h4, 16'(k));
            ix(1'b1, 4'h5, 16'h0003);
            i_core.sfr_read(8'hb5, rd8);
            check(rd8, 8'h15);
            wait_pulse(1'b1);
            check(by_pin, 1'b0);
            s = lf_count;
            wait_pulse(1'b1);
            check(lf_count - s, k + 1);
        end
        @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        ix(1'b0, 4'h6, 16'h0000);
        check(rv <= k, 1'b1);
        ix(1'b0, 4'h7, 16'h0000);
        check(rv[7:0], 8'h00);
        check(rv[15:8] < 8'h28, 1'b1);
        ix(1'b1, 4'h5, 16'h0000);
        ix(1'b1, 4'h5, 16'h0010);
        ix(1'b0, 4'h6, 16'h0000);
        check(rv, 16'h0000);
        ix(1'b1, 4'h5, 16'h0003);
        $display("wake timer test done");
        seed = lfsr_next(seed);
        d = seed[1:0] % 3;
        n = 1 + seed[3:2];
        i_core.sfr_write(8'hb6, 8'(d));
        ix(1'b1, 4'h0, 16'h0000);
        check(wdt_active, 1'b1);
        ix(1'b0, 4'h0, 16'h0000);
        check(rv, 16'h0000);
        ix(1'b1, 4'h0, 16'(n));
        s = lf_count;
        wait_pulse(1'b0);
        check(lf_count - s, n * (d + 1));
        i_core.sfr_read(8'hb6, rd8);
        check(rd8, 8'h03);
        wait_pulse(1'b1);
        s = lf_count;
        wait_pulse(1'b1);
        check(lf_count - s, k + 1);
        $display("watchdog expiry test done");
        ix(1'b1, 4'h5, 16'h0023);
        ix(1'b1, 4'h0, 16'h0100);
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        repeat (60) @(posedge clk);
        #1;
        check(wdt_active, 1'b0);
        ix(1'b1, 4'h5, 16'h0000);
        s = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (wake_irq !== 1'b0) begin
                s++;
            end
        end
        check(s, 0);
        @(posedge clk);
        pin <= 1'b1;
        wait_pulse(1'b1);
        check(by_pin, 1'b1);
        $display("sleep and pin wake test done");
        close_out();
    end
endmodule : tb

`default_nettype wire
